// ===== common/lrpv_pkg.sv
// Package with command codes, field positions, reset values and timing for the command decoder
package lrpv_pkg;

    // ----------------------------------------------------------------
    // Command codes and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] LRPV_CMD_RESET = 8'hE2;
    localparam logic [7:0] LRPV_CMD_IND_OFF = 8'hAC;
    localparam logic [7:0] LRPV_CMD_IND_ON = 8'hAD;
    localparam logic [7:0] LRPV_CMD_VOL_MODE = 8'h81;
    localparam logic [7:0] LRPV_CMD_NOP = 8'hE3;
    localparam logic [7:0] LRPV_CMD_RMW_END = 8'hEE;
    localparam logic [7:0] LRPV_CMD_TEST = 8'hF0;
    localparam logic [7:0] LRPV_MASK_SCAN = 8'hF0;
    localparam logic [7:0] LRPV_CODE_SCAN = 8'hC0;
    localparam logic [7:0] LRPV_MASK_PWR = 8'hF8;
    localparam logic [7:0] LRPV_CODE_PWR = 8'h28;
    localparam logic [7:0] LRPV_CODE_RATIO = 8'h20;
    localparam logic [7:0] LRPV_MASK_START = 8'hC0;
    localparam logic [7:0] LRPV_CODE_START = 8'h40;
    localparam logic [7:0] LRPV_MASK_PAGE = 8'hF0;
    localparam logic [7:0] LRPV_CODE_PAGE = 8'hB0;
    localparam logic [7:0] LRPV_MASK_COLHI = 8'hF0;
    localparam logic [7:0] LRPV_CODE_COLHI = 8'h10;
    localparam logic [7:0] LRPV_CODE_COLLO = 8'h00;
    localparam logic [7:0] LRPV_CMD_RMW = 8'hE0;
    localparam logic [7:0] LRPV_CMD_DISP_OFF = 8'hAE;
    localparam logic [7:0] LRPV_CMD_ALLON = 8'hA5;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int LRPV_BIT_SCAN = 3;
    localparam int LRPV_BIT_BOOST = 2;
    localparam int LRPV_BIT_REG = 1;
    localparam int LRPV_BIT_FOLLOW = 0;
    localparam int LRPV_STAT_RESET_BIT = 4;
    localparam logic [5:0] LRPV_VOL_RST = 6'h20;
    localparam logic [2:0] LRPV_RATIO_RST = 3'h0;
    localparam logic [1:0] LRPV_IND_RST = 2'h0;
    localparam logic [1:0] LRPV_IND_STEADY = 2'h3;
    localparam logic [1:0] LRPV_IND_SLOW = 2'h1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int LRPV_CLK_HZ = 40_000_000;
    localparam int LRPV_RESET_BUSY_CYC = 4;
    localparam int LRPV_BLINK_FAST_MS = 500;
    localparam int LRPV_BLINK_FAST_CYC = LRPV_CLK_HZ / 1000 * LRPV_BLINK_FAST_MS;

    typedef enum logic [1:0]
    {
        LRPV_ST_IDLE = 2'b00,
        LRPV_ST_VOL = 2'b01,
        LRPV_ST_IND = 2'b10
    } lrpv_state_e;

endpackage : lrpv_pkg

// ===== hw/lrpv_cmd.sv
// Command decoder for reset, scan direction, power, resistor ratio, volume and indicator
`timescale 1ns/1ps

//Contract
//- Reset command reinitialises listed modes
//- Reset command leaves display memory untouched
//- Reset acts after command byte accepted
//- 1100 byte picks scan direction bit3
//- 00101 byte sets booster regulator follower
//- 00100 byte loads resistor ratio
//- After volume mode, next byte is value
//- Volume is low six bits
//- AC turns indicator off, AD pends
//- After AD only indicator register accepted
//- Indicator register low two bits, blink codes
//- Indicator changes only by own commands and by reset
//- Indicator drives segment output; frame output toggles every clk regardless
//- Status bit4 high during reset
//- Power save sleep or standby choice
module lrpv_cmd
#(
    parameter int BLINK_FAST_CYC = lrpv_pkg::LRPV_BLINK_FAST_CYC
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hw_reset_pin_n,
    input wire logic wr_strobe,
    input wire logic cmd_data_select,
    input wire logic [7:0] wr_data,
    input wire logic power_save_req,
    output logic scan_reverse,
    output logic boost_en,
    output logic regulator_en,
    output logic follower_en,
    output logic [2:0] regulator_resistor_ratio,
    output logic [5:0] lcd_drive_level,
    output logic [1:0] indicator_mode,
    output logic frame_polarity_out,
    output logic static_segment_out,
    output logic [7:0] status_byte,
    output logic init_pulse,
    output logic rmw_exit,
    output logic test_exit,
    output logic sleep_mode,
    output logic standby_mode
);
    import lrpv_pkg::*;

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_s1, rst_n;
    logic [1:0] pin_s;
    logic [1:0] wr_s;
    logic wr_d;
    logic [7:0] data_s;
    logic [7:0] data_q;
    logic sel_s;
    logic sel_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Strobe is asynchronous to clk; data and select must be stable around it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Pin idles high; any other reset value fakes a pin reset after release
            pin_s <= 2'b11;
            wr_s <= 2'b00;
            wr_d <= 1'b0;
        end
        else
        begin
            pin_s <= {pin_s[0], hw_reset_pin_n};
            wr_s <= {wr_s[0], wr_strobe};
            wr_d <= wr_s[1];
        end
    end

    // Two stages on the bus too; the byte is held long after the strobe falls
    always_ff @(posedge clk)
    begin
        data_s <= wr_data;
        sel_s <= cmd_data_select;
        data_q <= data_s;
        sel_q <= sel_s;
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire pin_reset = !pin_s[1];
    wire wr_end = wr_d && !wr_s[1];
    wire cmd_take = wr_end && !sel_q;
    lrpv_state_e state, next_state;
    wire in_idle = (state == LRPV_ST_IDLE);
    wire dec_reset = cmd_take && in_idle && (data_q == LRPV_CMD_RESET);
    wire dec_scan = cmd_take && in_idle && ((data_q & LRPV_MASK_SCAN) == LRPV_CODE_SCAN);
    wire dec_pwr = cmd_take && in_idle && ((data_q & LRPV_MASK_PWR) == LRPV_CODE_PWR);
    wire dec_ratio = cmd_take && in_idle && ((data_q & LRPV_MASK_PWR) == LRPV_CODE_RATIO);
    wire dec_vmode = cmd_take && in_idle && (data_q == LRPV_CMD_VOL_MODE);
    wire dec_ioff = cmd_take && in_idle && (data_q == LRPV_CMD_IND_OFF);
    wire dec_ion = cmd_take && in_idle && (data_q == LRPV_CMD_IND_ON);
    wire dec_vval = cmd_take && (state == LRPV_ST_VOL);
    wire dec_ival = cmd_take && (state == LRPV_ST_IND);
    wire dec_rmw_end = cmd_take && in_idle && (data_q == LRPV_CMD_RMW_END);
    wire dec_nop = cmd_take && in_idle && (data_q == LRPV_CMD_NOP);

    always_comb
    begin
        next_state = state;
        case (state)
            LRPV_ST_IDLE:
            begin
                if (dec_vmode)
                    next_state = LRPV_ST_VOL;
                else if (dec_ion)
                    next_state = LRPV_ST_IND;
            end
            LRPV_ST_VOL:
                if (cmd_take)
                    next_state = LRPV_ST_IDLE;
            LRPV_ST_IND:
                if (cmd_take)
                    next_state = LRPV_ST_IDLE;
            default:
                next_state = LRPV_ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    logic [2:0] busy_cnt;
    wire soft_init = (busy_cnt == 3'(LRPV_RESET_BUSY_CYC)) && !pin_reset;
    wire do_init = pin_reset || soft_init;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            busy_cnt <= 3'h0;
        else if (pin_reset)
            busy_cnt <= 3'h1;
        else if (dec_reset)
            busy_cnt <= 3'(LRPV_RESET_BUSY_CYC);
        else if (busy_cnt != 3'h0)
            busy_cnt <= busy_cnt - 3'h1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= LRPV_ST_IDLE;
        else if (do_init)
            state <= LRPV_ST_IDLE;
        else
            state <= next_state;
    end

    // Only mode state is cleared; no display memory lives here.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scan_reverse <= 1'b0;
            regulator_resistor_ratio <= LRPV_RATIO_RST;
            lcd_drive_level <= LRPV_VOL_RST;
            indicator_mode <= LRPV_IND_RST;
        end
        else if (do_init)
        begin
            scan_reverse <= 1'b0;
            regulator_resistor_ratio <= LRPV_RATIO_RST;
            lcd_drive_level <= LRPV_VOL_RST;
            indicator_mode <= LRPV_IND_RST;
        end
        else
        begin
            if (dec_scan)
                scan_reverse <= data_q[LRPV_BIT_SCAN];
            if (dec_ratio)
                regulator_resistor_ratio <= data_q[2:0];
            if (dec_vval)
                lcd_drive_level <= data_q[5:0];
            if (dec_ioff)
                indicator_mode <= LRPV_IND_RST;
            else if (dec_ival)
                indicator_mode <= data_q[1:0];
        end
    end

    // Power enables are not in the software reset set
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boost_en <= 1'b0;
            regulator_en <= 1'b0;
            follower_en <= 1'b0;
        end
        else if (pin_reset)
        begin
            boost_en <= 1'b0;
            regulator_en <= 1'b0;
            follower_en <= 1'b0;
        end
        else if (dec_pwr)
        begin
            boost_en <= data_q[LRPV_BIT_BOOST];
            regulator_en <= data_q[LRPV_BIT_REG];
            follower_en <= data_q[LRPV_BIT_FOLLOW];
        end
    end

    // ----------------------------------------------------------------
    // Power save, status and side pulses
    // ----------------------------------------------------------------
    wire ind_on = (indicator_mode != LRPV_IND_RST);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleep_mode <= 1'b0;
            standby_mode <= 1'b0;
            init_pulse <= 1'b0;
            rmw_exit <= 1'b0;
            test_exit <= 1'b0;
            status_byte <= 8'h00;
        end
        else
        begin
            init_pulse <= do_init;
            rmw_exit <= do_init || dec_rmw_end;
            test_exit <= do_init || dec_nop;
            status_byte <= {3'b000, busy_cnt != 3'h0 || pin_reset, 4'h0};
            if (!power_save_req || pin_reset)
            begin
                sleep_mode <= 1'b0;
                standby_mode <= 1'b0;
            end
            else if (dec_reset && standby_mode)
            begin
                sleep_mode <= 1'b1;
                standby_mode <= 1'b0;
            end
            else if (!sleep_mode && !standby_mode)
            begin
                sleep_mode <= !ind_on;
                standby_mode <= ind_on;
            end
        end
    end

    // ----------------------------------------------------------------
    // Static indicator drive
    // ----------------------------------------------------------------
    logic [25:0] blink_cnt;
    logic blink_ph;
    logic fr_toggle;
    wire [25:0] blink_lim = (indicator_mode == LRPV_IND_SLOW) ?
        26'(2 * BLINK_FAST_CYC - 1) : 26'(BLINK_FAST_CYC - 1);
    wire seg_on = (indicator_mode == LRPV_IND_STEADY) || (ind_on && blink_ph);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_cnt <= 26'h0;
            blink_ph <= 1'b1;
            fr_toggle <= 1'b0;
            frame_polarity_out <= 1'b0;
            static_segment_out <= 1'b0;
        end
        else
        begin
            fr_toggle <= !fr_toggle;
            if (blink_cnt >= blink_lim)
            begin
                blink_cnt <= 26'h0;
                blink_ph <= !blink_ph;
            end
            else
                blink_cnt <= blink_cnt + 26'h1;
            // Segment in phase with frame gives zero volts, out of phase lights it
            frame_polarity_out <= fr_toggle;
            static_segment_out <= (seg_on && !sleep_mode) ? !fr_toggle : fr_toggle;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_vol_load: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vval && !do_init |=> lcd_drive_level == $past(data_q[5:0]))
        else $error("volume value not stored");
    chk_vol_mode: assert property (@(posedge clk) disable iff (!rst_n)
        dec_vval && !do_init |=> state == LRPV_ST_IDLE)
        else $error("volume mode not released");
    chk_scan_sel: assert property (@(posedge clk) disable iff (!rst_n)
        dec_scan && !do_init |=> scan_reverse == $past(data_q[3]))
        else $error("scan direction wrong");
    chk_pwr_bits: assert property (@(posedge clk) disable iff (!rst_n)
        dec_pwr && !pin_reset |=> {boost_en, regulator_en, follower_en} == $past(data_q[2:0]))
        else $error("power enables wrong");
    chk_ratio_load: assert property (@(posedge clk) disable iff (!rst_n)
        dec_ratio && !do_init |=> regulator_resistor_ratio == $past(data_q[2:0]))
        else $error("ratio wrong");
    chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
        dec_reset && !pin_reset ##1 !pin_reset [*4] |=> lcd_drive_level == LRPV_VOL_RST
        && indicator_mode == LRPV_IND_RST && !scan_reverse)
        else $error("soft reset incomplete");
    chk_no_early: assert property (@(posedge clk) disable iff (!rst_n)
        dec_reset && !pin_reset |=> !init_pulse)
        else $error("reset acted before byte done");
    chk_busy_flag: assert property (@(posedge clk) disable iff (!rst_n)
        dec_reset |=> ##1 status_byte[4])
        else $error("reset flag not shown");
    chk_ind_off: assert property (@(posedge clk) disable iff (!rst_n)
        dec_ioff && !do_init |=> indicator_mode == LRPV_IND_RST && state == LRPV_ST_IDLE)
        else $error("indicator off failed");
    chk_ind_mode: assert property (@(posedge clk) disable iff (!rst_n)
        dec_ival && !do_init |=> indicator_mode == $past(data_q[1:0]) && in_idle)
        else $error("indicator register wrong");
    cov_vol_pair: cover property (@(posedge clk) disable iff (!rst_n) dec_vmode ##[1:50] dec_vval);
    cov_ind_pair: cover property (@(posedge clk) disable iff (!rst_n) dec_ion ##[1:50] dec_ival);
    cov_soft_rst: cover property (@(posedge clk) disable iff (!rst_n) dec_reset ##2 init_pulse);
    cov_standby: cover property (@(posedge clk) disable iff (!rst_n) standby_mode ##1 sleep_mode);

endmodule : lrpv_cmd

// ===== verif/lrpv_host.sv
// Host model that writes one command or data byte per request with a full write strobe
`timescale 1ns/1ps
module lrpv_host
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic req,
    input wire logic req_sel,
    input wire logic [7:0] req_data,
    output logic done,
    output logic wr_strobe,
    output logic cmd_data_select,
    output logic [7:0] wr_data
);
    // ----------------------------------------------------------------
    // Write cycle sequencer
    // ----------------------------------------------------------------
    logic busy;
    logic [3:0] cnt;
    // Strobe high 4 clk, low with byte held 6 clk so the decoder can sample it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
            wr_strobe <= 1'b0;
            cmd_data_select <= 1'b1;
            wr_data <= 8'h00;
        end
        else
        begin
            done <= 1'b0;
            if (!busy && req)
            begin
                busy <= 1'b1;
                cnt <= 4'h0;
                wr_strobe <= 1'b1;
                cmd_data_select <= req_sel;
                wr_data <= req_data;
            end
            else if (busy)
            begin
                cnt <= cnt + 4'h1;
                if (cnt == 4'h3)
                    wr_strobe <= 1'b0;
                if (cnt == 4'h9)
                begin
                    // Released bus shows the inverse so stale bytes cannot match
                    wr_data <= ~wr_data;
                    cmd_data_select <= 1'b1;
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule : lrpv_host

// ===== verif/lrpv_cmd_tb.sv
// Testbench for the command decoder, driving byte writes through the host model
`timescale 1ns/1ps
module lrpv_cmd_tb;
    import lrpv_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hw_reset_pin_n = 1'b1;
    logic power_save_req = 1'b0;
    logic req = 1'b0;
    logic req_sel = 1'b0;
    logic [7:0] req_data = 8'h00;
    logic done, wr_strobe, cmd_data_select, scan_reverse, boost_en, regulator_en, follower_en;
    logic frame_polarity_out, static_segment_out, init_pulse, rmw_exit, test_exit;
    logic sleep_mode, standby_mode;
    logic [7:0] wr_data, status_byte;
    logic [2:0] regulator_resistor_ratio;
    logic [5:0] lcd_drive_level;
    logic [1:0] indicator_mode;
    logic seen_busy = 1'b0, seen_init = 1'b0, seen_rmw = 1'b0, seen_test = 1'b0, early = 1'b0;
    logic [7:0] vol_in [3] = '{8'hE2, 8'h20, 8'hFF};
    logic [5:0] vol_exp [3] = '{6'h22, 6'h20, 6'h3F};
    int err_count = 0;
    int checks = 0;
    int i;
    always #12.5 clk = ~clk;
    lrpv_host u_host (.clk(clk), .resetn(resetn), .req(req), .req_sel(req_sel),
        .req_data(req_data), .done(done), .wr_strobe(wr_strobe),
        .cmd_data_select(cmd_data_select), .wr_data(wr_data));
    lrpv_cmd #(.BLINK_FAST_CYC(8)) u_dut (.clk(clk), .resetn(resetn),
        .hw_reset_pin_n(hw_reset_pin_n), .wr_strobe(wr_strobe),
        .cmd_data_select(cmd_data_select), .wr_data(wr_data), .power_save_req(power_save_req),
        .scan_reverse(scan_reverse), .boost_en(boost_en), .regulator_en(regulator_en),
        .follower_en(follower_en), .regulator_resistor_ratio(regulator_resistor_ratio),
        .lcd_drive_level(lcd_drive_level), .indicator_mode(indicator_mode),
        .frame_polarity_out(frame_polarity_out), .static_segment_out(static_segment_out),
        .status_byte(status_byte), .init_pulse(init_pulse), .rmw_exit(rmw_exit),
        .test_exit(test_exit), .sleep_mode(sleep_mode), .standby_mode(standby_mode));
    // ----------------------------------------------------------------
    // Sticky monitors for short pulses
    // ----------------------------------------------------------------
    always @(negedge clk)
    begin
        if (status_byte[LRPV_STAT_RESET_BIT] === 1'b1) seen_busy = 1'b1;
        if (init_pulse === 1'b1) seen_init = 1'b1;
        if (init_pulse === 1'b1 && wr_strobe === 1'b1) early = 1'b1;
        if (rmw_exit === 1'b1) seen_rmw = 1'b1;
        if (test_exit === 1'b1) seen_test = 1'b1;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic summarize;
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic send(input logic sel, input logic [7:0] data);
        int n;
        @(posedge clk);
        req <= 1'b1;
        req_sel <= sel;
        req_data <= data;
        @(posedge clk);
        req <= 1'b0;
        for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge clk);
        chk("write done", 8'h01, {7'h00, done});
        if (done !== 1'b1) summarize();
        repeat (3) @(negedge clk);
    endtask : send
    task automatic cmd(input logic [7:0] data);
        send(1'b0, data);
    endtask : cmd
    task automatic pwr(input logic [7:0] exp);
        chk("power", exp, {5'h00, boost_en, regulator_en, follower_en});
    endtask : pwr
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(negedge clk);
        chk("level", {2'b00, LRPV_VOL_RST}, {2'b00, lcd_drive_level});
        chk("status", 8'h00, status_byte);
        cmd(8'hC8);
        chk("scan", 8'h01, {7'h00, scan_reverse});
        cmd(8'hC7);
        chk("scan", 8'h00, {7'h00, scan_reverse});
        for (i = 0; i < 8; i++)
        begin
            cmd(LRPV_CODE_PWR | i[7:0]);
            pwr(i[7:0]);
        end
        cmd(8'h27);
        chk("ratio", 8'h07, {5'h00, regulator_resistor_ratio});
        cmd(8'h25);
        chk("ratio", 8'h05, {5'h00, regulator_resistor_ratio});
        seen_init = 1'b0;
        // Value bytes that look like commands must land in the register
        for (i = 0; i < 3; i++)
        begin
            cmd(LRPV_CMD_VOL_MODE);
            cmd(vol_in[i]);
            chk("level", {2'b00, vol_exp[i]}, {2'b00, lcd_drive_level});
        end
        chk("no init", 8'h00, {7'h00, seen_init});
        cmd(8'hC8);
        chk("scan", 8'h01, {7'h00, scan_reverse});
        cmd(LRPV_CMD_IND_ON);
        cmd(LRPV_CMD_DISP_OFF);
        chk("indicator", 8'h02, {6'h00, indicator_mode});
        cmd(LRPV_CMD_IND_ON);
        cmd(8'hFD);
        chk("indicator", 8'h01, {6'h00, indicator_mode});
        cmd(LRPV_CMD_IND_ON);
        cmd(8'hF3);
        cmd(LRPV_CMD_DISP_OFF);
        cmd(LRPV_CMD_ALLON);
        cmd(8'hA6);
        cmd(8'hAF);
        chk("indicator", 8'h03, {6'h00, indicator_mode});
        repeat (2)
        begin
            @(negedge clk);
            chk("segment lit", {7'h00, ~frame_polarity_out}, {7'h00, static_segment_out});
        end
        cmd(LRPV_CMD_IND_OFF);
        chk("indicator", 8'h00, {6'h00, indicator_mode});
        chk("segment off", {7'h00, frame_polarity_out}, {7'h00, static_segment_out});
        send(1'b1, 8'hC0);
        chk("scan", 8'h01, {7'h00, scan_reverse});
        cmd(LRPV_CMD_RMW_END);
        cmd(LRPV_CMD_NOP);
        chk("exits", 8'h03, {6'h00, seen_rmw, seen_test});
        seen_init = 1'b0;
        seen_busy = 1'b0;
        seen_rmw = 1'b0;
        seen_test = 1'b0;
        cmd(LRPV_CMD_RESET);
        repeat (10) @(negedge clk);
        chk("busy seen", 8'h01, {7'h00, seen_busy});
        chk("init", 8'h13, {3'h0, seen_init, 2'h0, seen_rmw, seen_test});
        chk("early", 8'h00, {7'h00, early});
        chk("scan", 8'h00, {7'h00, scan_reverse});
        chk("ratio", 8'h00, {5'h00, regulator_resistor_ratio});
        chk("level", 8'h20, {2'b00, lcd_drive_level});
        chk("indicator", 8'h00, {6'h00, indicator_mode});
        pwr(8'h07);
        chk("status", 8'h00, status_byte);
        @(posedge clk);
        power_save_req <= 1'b1;
        repeat (5) @(negedge clk);
        chk("save", 8'h02, {6'h00, sleep_mode, standby_mode});
        @(posedge clk);
        power_save_req <= 1'b0;
        repeat (5) @(negedge clk);
        cmd(LRPV_CMD_IND_ON);
        cmd(8'h03);
        @(posedge clk);
        power_save_req <= 1'b1;
        repeat (5) @(negedge clk);
        chk("save", 8'h01, {6'h00, sleep_mode, standby_mode});
        cmd(LRPV_CMD_RESET);
        repeat (10) @(negedge clk);
        chk("save", 8'h02, {6'h00, sleep_mode, standby_mode});
        @(posedge clk);
        power_save_req <= 1'b0;
        hw_reset_pin_n <= 1'b0;
        repeat (5) @(negedge clk);
        chk("status", 8'h10, status_byte);
        pwr(8'h00);
        @(posedge clk);
        hw_reset_pin_n <= 1'b1;
        repeat (12) @(negedge clk);
        chk("status", 8'h00, status_byte);
        summarize();
    end
endmodule : lrpv_cmd_tb
